// File: hw/stp_regs.svh
`ifndef STP_REGS_SVH
`define STP_REGS_SVH
`define STP_IR_WIDTH 4
`define STP_IR_RESET 4'h1
`define STP_IR_BYPASS 4'hF
`define STP_IR_IDCODE 4'h1
`define STP_IR_EMUCFG 4'h8
`define STP_EMUCFG_WIDTH 2
`define STP_EMUCFG_RESET 2'h0
`define STP_EMUCFG_A_DIR 0
`define STP_EMUCFG_B_DIR 1
`endif

// File: hw/stp_pkg.sv
package stp_pkg;
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET = 4'h0,
    RUN_IDLE = 4'h1,
    SELECT_DR = 4'h2,
    CAPTURE_DR = 4'h3,
    SHIFT_DR = 4'h4,
    EXIT1_DR = 4'h5,
    PAUSE_DR = 4'h6,
    EXIT2_DR = 4'h7,
    UPDATE_DR = 4'h8,
    SELECT_IR = 4'h9,
    CAPTURE_IR = 4'hA,
    SHIFT_IR = 4'hB,
    EXIT1_IR = 4'hC,
    PAUSE_IR = 4'hD,
    EXIT2_IR = 4'hE,
    UPDATE_IR = 4'hF
  } stp_tap_state_t;

  typedef struct packed {
    logic testClk;
    logic modeSelect;
    logic dataIn;
    logic testReset;
  } stp_scan_in_t;

  typedef struct packed {
    logic emuAOut;
    logic emuAOutEnN;
    logic emuBOut;
    logic emuBOutEnN;
  } stp_emu_drive_t;
endpackage : stp_pkg

// File: hw/stp_scan_port.sv
`timescale 1ns/1ps
`include "stp_regs.svh"
module stp_scan_port #(
  parameter logic [31:0] ID_CODE = 32'h0000_1001 // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // scan pins, asynchronous to clk_sys
  input wire stp_pkg::stp_scan_in_t scanIn,
  output logic testDataOut_ff,
  output logic testDataOutEnN_ff,
  // emulation pins
  input wire logic emulationPinAIn,
  input wire logic emulationPinBIn,
  output stp_pkg::stp_emu_drive_t emuDrive_ff,
  // emulator interrupt exchange with the core
  input wire logic coreEmuIrqA,
  input wire logic coreEmuIrqB,
  output logic emuIrqFromA_ff,
  output logic emuIrqFromB_ff,
  // host port outputs from the core
  input wire logic hostReadyCore,
  input wire logic hostIntCore,
  output logic hostPortReadyOut_ff,
  output logic hostPortReadyOutEnN_ff,
  output logic hostInterruptOut_ff,
  output logic hostInterruptOutEnN_ff,
  // global state
  output logic scanControl_ff,
  output logic outputDisable_ff
);
  localparam int IRW = `STP_IR_WIDTH;
  localparam int EW = `STP_EMUCFG_WIDTH;

  // two-flop synchronisers; stage one is read only by stage two
  logic [3:0] syncA_ff, syncB_ff, nxt_syncA, nxt_syncB;
  logic [1:0] emuSyncA_ff, emuSyncB_ff, nxt_emuSyncA, nxt_emuSyncB;
  logic tckPrev_ff, nxt_tckPrev;
  logic tck, tms, tdi, trst, emuA, emuB, tckRise, tckFall;

  always_comb begin
    nxt_syncA = scanIn;
    nxt_syncB = syncA_ff;
    nxt_emuSyncA = {emulationPinAIn, emulationPinBIn};
    nxt_emuSyncB = emuSyncA_ff;
    nxt_tckPrev = tck;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      syncA_ff <= 4'h0;
      syncB_ff <= 4'h0;
      emuSyncA_ff <= 2'h0;
      emuSyncB_ff <= 2'h0;
      tckPrev_ff <= 1'b0;
    end else begin
      syncA_ff <= nxt_syncA;
      syncB_ff <= nxt_syncB;
      emuSyncA_ff <= nxt_emuSyncA;
      emuSyncB_ff <= nxt_emuSyncB;
      tckPrev_ff <= nxt_tckPrev;
    end
  end

  assign tck = syncB_ff[3];
  assign tms = syncB_ff[2];
  assign tdi = syncB_ff[1];
  assign trst = syncB_ff[0];
  assign emuA = emuSyncB_ff[1];
  assign emuB = emuSyncB_ff[0];
  assign tckRise = tck & ~tckPrev_ff;
  assign tckFall = ~tck & tckPrev_ff;

  function automatic stp_pkg::stp_tap_state_t tapNext(
    input stp_pkg::stp_tap_state_t s, input logic m);
    unique case (s)
      stp_pkg::TEST_LOGIC_RESET:
        tapNext = m ? stp_pkg::TEST_LOGIC_RESET : stp_pkg::RUN_IDLE;
      stp_pkg::RUN_IDLE: tapNext = m ? stp_pkg::SELECT_DR : stp_pkg::RUN_IDLE;
      stp_pkg::SELECT_DR:
        tapNext = m ? stp_pkg::SELECT_IR : stp_pkg::CAPTURE_DR;
      stp_pkg::CAPTURE_DR: tapNext = m ? stp_pkg::EXIT1_DR : stp_pkg::SHIFT_DR;
      stp_pkg::SHIFT_DR: tapNext = m ? stp_pkg::EXIT1_DR : stp_pkg::SHIFT_DR;
      stp_pkg::EXIT1_DR: tapNext = m ? stp_pkg::UPDATE_DR : stp_pkg::PAUSE_DR;
      stp_pkg::PAUSE_DR: tapNext = m ? stp_pkg::EXIT2_DR : stp_pkg::PAUSE_DR;
      stp_pkg::EXIT2_DR: tapNext = m ? stp_pkg::UPDATE_DR : stp_pkg::SHIFT_DR;
      stp_pkg::UPDATE_DR: tapNext = m ? stp_pkg::SELECT_DR : stp_pkg::RUN_IDLE;
      stp_pkg::SELECT_IR:
        tapNext = m ? stp_pkg::TEST_LOGIC_RESET : stp_pkg::CAPTURE_IR;
      stp_pkg::CAPTURE_IR: tapNext = m ? stp_pkg::EXIT1_IR : stp_pkg::SHIFT_IR;
      stp_pkg::SHIFT_IR: tapNext = m ? stp_pkg::EXIT1_IR : stp_pkg::SHIFT_IR;
      stp_pkg::EXIT1_IR: tapNext = m ? stp_pkg::UPDATE_IR : stp_pkg::PAUSE_IR;
      stp_pkg::PAUSE_IR: tapNext = m ? stp_pkg::EXIT2_IR : stp_pkg::PAUSE_IR;
      stp_pkg::EXIT2_IR: tapNext = m ? stp_pkg::UPDATE_IR : stp_pkg::SHIFT_IR;
      stp_pkg::UPDATE_IR: tapNext = m ? stp_pkg::SELECT_DR : stp_pkg::RUN_IDLE;
    endcase
  endfunction : tapNext

  // tap state, instruction and data registers
  stp_pkg::stp_tap_state_t tap_ff, nxt_tap;
  logic [IRW-1:0] irShift_ff, nxt_irShift, ir_ff, nxt_ir;
  logic [31:0] drShift_ff, nxt_drShift;
  logic [EW-1:0] emuCfg_ff, nxt_emuCfg;
  logic shiftBit, shiftingNow;

  always_comb begin
    nxt_tap = tap_ff;
    nxt_irShift = irShift_ff;
    nxt_ir = ir_ff;
    nxt_drShift = drShift_ff;
    nxt_emuCfg = emuCfg_ff;
    if (!trst) begin
      // test reset low holds the tap in reset, scan pins ignored
      nxt_tap = stp_pkg::TEST_LOGIC_RESET;
      nxt_ir = `STP_IR_RESET;
      nxt_emuCfg = `STP_EMUCFG_RESET;
    end else if (tckRise) begin
      nxt_tap = tapNext(tap_ff, tms);
      unique case (tap_ff)
        stp_pkg::TEST_LOGIC_RESET: begin
          nxt_ir = `STP_IR_RESET;
          nxt_emuCfg = `STP_EMUCFG_RESET;
        end
        stp_pkg::CAPTURE_IR: nxt_irShift = {{(IRW-2){1'b0}}, 2'b01};
        stp_pkg::SHIFT_IR:
          nxt_irShift = {tdi, irShift_ff[IRW-1:1]};
        stp_pkg::UPDATE_IR: nxt_ir = irShift_ff;
        stp_pkg::CAPTURE_DR: begin
          if (ir_ff == `STP_IR_IDCODE) begin
            nxt_drShift = ID_CODE;
          end else if (ir_ff == `STP_IR_EMUCFG) begin
            nxt_drShift = {{(32-EW){1'b0}}, emuCfg_ff};
          end else begin
            nxt_drShift = 32'h0000_0000;
          end
        end
        stp_pkg::SHIFT_DR: begin
          if (ir_ff == `STP_IR_IDCODE) begin
            nxt_drShift = {tdi, drShift_ff[31:1]};
          end else if (ir_ff == `STP_IR_EMUCFG) begin
            nxt_drShift = {30'h0000_0000, tdi, drShift_ff[1]};
          end else begin
            nxt_drShift = {31'h0000_0000, tdi};
          end
        end
        // pin direction is set through the scan system
        stp_pkg::UPDATE_DR: begin
          if (ir_ff == `STP_IR_EMUCFG) begin
            nxt_emuCfg = drShift_ff[EW-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tap_ff <= stp_pkg::TEST_LOGIC_RESET;
      irShift_ff <= '0;
      ir_ff <= `STP_IR_RESET;
      drShift_ff <= 32'h0000_0000;
      emuCfg_ff <= `STP_EMUCFG_RESET;
    end else begin
      tap_ff <= nxt_tap;
      irShift_ff <= nxt_irShift;
      ir_ff <= nxt_ir;
      drShift_ff <= nxt_drShift;
      emuCfg_ff <= nxt_emuCfg;
    end
  end

  assign shiftingNow = trst &&
    (tap_ff == stp_pkg::SHIFT_IR || tap_ff == stp_pkg::SHIFT_DR);
  assign shiftBit = (tap_ff == stp_pkg::SHIFT_IR) ? irShift_ff[0]
                                                   : drShift_ff[0];

  // pin outputs; the output enables are active low
  logic nxt_tdo, nxt_tdoEnN, nxt_off, nxt_scanCtl;
  logic nxt_irqA, nxt_irqB, nxt_hrdyEnN, nxt_hintEnN;
  stp_pkg::stp_emu_drive_t nxt_emu;
  logic offNow;

  // uses synchronised pins so a glitch cannot float the whole device
  assign offNow = !trst && emuA && !emuB;

  always_comb begin
    nxt_off = offNow;
    nxt_scanCtl = trst;
    nxt_tdo = testDataOut_ff;
    nxt_tdoEnN = testDataOutEnN_ff;
    if (tckFall) begin
      nxt_tdo = shiftBit;
      nxt_tdoEnN = !shiftingNow;
    end
    if (!trst) begin
      nxt_tdoEnN = 1'b1;
    end
    if (offNow) begin
      nxt_tdoEnN = 1'b1;
    end
    nxt_emu.emuAOut = coreEmuIrqA;
    nxt_emu.emuBOut = coreEmuIrqB;
    nxt_emu.emuAOutEnN = !(trst && emuCfg_ff[`STP_EMUCFG_A_DIR]);
    nxt_emu.emuBOutEnN = !(trst && emuCfg_ff[`STP_EMUCFG_B_DIR]);
    nxt_irqA = trst && !emuCfg_ff[`STP_EMUCFG_A_DIR] && !emuA;
    nxt_irqB = trst && !emuCfg_ff[`STP_EMUCFG_B_DIR] && !emuB;
    nxt_hrdyEnN = offNow;
    nxt_hintEnN = offNow;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      testDataOut_ff <= 1'b0;
      testDataOutEnN_ff <= 1'b1;
      emuDrive_ff <= 4'h5;
      emuIrqFromA_ff <= 1'b0;
      emuIrqFromB_ff <= 1'b0;
      hostPortReadyOut_ff <= 1'b0;
      hostPortReadyOutEnN_ff <= 1'b0;
      hostInterruptOut_ff <= 1'b1;
      hostInterruptOutEnN_ff <= 1'b0;
      scanControl_ff <= 1'b0;
      outputDisable_ff <= 1'b0;
    end else begin
      testDataOut_ff <= nxt_tdo;
      testDataOutEnN_ff <= nxt_tdoEnN;
      emuDrive_ff <= nxt_emu;
      emuIrqFromA_ff <= nxt_irqA;
      emuIrqFromB_ff <= nxt_irqB;
      hostPortReadyOut_ff <= hostReadyCore;
      hostPortReadyOutEnN_ff <= nxt_hrdyEnN;
      hostInterruptOut_ff <= hostIntCore;
      hostInterruptOutEnN_ff <= nxt_hintEnN;
      scanControl_ff <= nxt_scanCtl;
      outputDisable_ff <= nxt_off;
    end
  end
endmodule : stp_scan_port

// File: test/stp_scan_port_monitor.sv
`timescale 1ns/1ps
module stp_scan_port_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // pins
  input wire stp_pkg::stp_scan_in_t scanIn,
  input wire logic emulationPinAIn,
  input wire logic emulationPinBIn,
  // outputs
  input wire logic testDataOut_ff,
  input wire logic testDataOutEnN_ff,
  input wire logic hostPortReadyOutEnN_ff,
  input wire logic hostInterruptOutEnN_ff,
  input wire logic scanControl_ff,
  input wire logic outputDisable_ff
);
  wire logic offPin = !scanIn.testReset && emulationPinAIn &&
    !emulationPinBIn;
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // pins cross two sync stages, so a few cycles of slack are allowed
  sequence offHeld; offPin [*5]; endsequence
  sequence scanHeld; scanIn.testReset [*5]; endsequence
  sequence funcHeld; !scanIn.testReset [*7]; endsequence
  tdo_fall_edge_a: assert property (
    !testDataOutEnN_ff && $changed(testDataOut_ff) |-> !scanIn.testClk)
    else $error("tdo moved with test clock high");
  tdo_idle_float_a: assert property (
    funcHeld |-> testDataOutEnN_ff) else $error("tdo driven in reset");
  off_enter_a: assert property (
    offHeld |-> outputDisable_ff) else $error("disable missing");
  off_cause_a: assert property (
    outputDisable_ff |-> $past(offPin, 2) || $past(offPin, 3) ||
    $past(offPin, 4)) else $error("disable without cause");
  off_float_a: assert property (
    outputDisable_ff && $past(outputDisable_ff) |-> testDataOutEnN_ff &&
    hostPortReadyOutEnN_ff && hostInterruptOutEnN_ff)
    else $error("driver on while disabled");
  scan_owner_a: assert property (
    scanHeld |-> scanControl_ff) else $error("scan control missing");
  func_mode_a: assert property (
    funcHeld |-> !scanControl_ff) else $error("scan control in reset");
  host_drive_a: assert property (
    !outputDisable_ff [*2] |-> !hostPortReadyOutEnN_ff &&
    !hostInterruptOutEnN_ff) else $error("host pins float");
endmodule : stp_scan_port_monitor

bind stp_scan_port stp_scan_port_monitor i_stp_scan_port_monitor (.clk_sys,
  .nrst, .scanIn, .emulationPinAIn, .emulationPinBIn, .testDataOut_ff,
  .testDataOutEnN_ff, .hostPortReadyOutEnN_ff, .hostInterruptOutEnN_ff,
  .scanControl_ff, .outputDisable_ff);

// File: test/stp_tester.sv
`timescale 1ns/1ps
module stp_tester (
  // scan pins toward the device
  output stp_pkg::stp_scan_in_t scanIn,
  // test data return
  input wire logic tdo,
  input wire logic tdoEnN
);
  // clock rests low between frames; mode and data rest at pull-up level
  initial scanIn = 4'h6;
  // test reset is raised for test sessions only, never for bus sharing
  task automatic setReset(input logic v);
    scanIn.testReset = v;
  endtask : setReset
  // one 125 ns test clock; tdo is read just before the rising edge
  task automatic step(input logic tms, input logic tdi,
      output logic q, output logic qEnN);
    scanIn.modeSelect = tms;
    scanIn.dataIn = tdi;
    #62.5;
    q = tdo;
    qEnN = tdoEnN;
    scanIn.testClk = 1'b1;
    #62.5;
    scanIn.testClk = 1'b0;
  endtask : step
  task automatic home();
    logic q, e;
    for (int i = 0; i < 6; i++) step(i < 5, 1'b1, q, e);
  endtask : home
  // run-idle, one ir or dr scan of n bits lsb first, back to run-idle
  task automatic scan(input logic isIr, input int n, input logic [31:0] d,
      output logic [31:0] dout, output int driven);
    logic q, e;
    dout = '0;
    driven = 0;
    step(1'b1, 1'b1, q, e);
    if (isIr) step(1'b1, 1'b1, q, e);
    for (int i = 0; i < 2; i++) step(1'b0, 1'b1, q, e);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], q, e);
      dout[i] = q;
      if (e === 1'b0) driven++;
    end
    step(1'b1, 1'b1, q, e);
    step(1'b0, 1'b1, q, e);
    scanIn[2:1] = 2'b11;
  endtask : scan
endmodule : stp_tester

// File: test/stp_scan_port_test.sv
`timescale 1ns/1ps
module stp_scan_port_test;
  localparam logic [31:0] ID = 32'h0000_2A5B; // arbitrary value
  logic clk_sys, nrst, pinADrv, pinBDrv, coreEmuIrqA, coreEmuIrqB;
  logic hostReadyCore, hostIntCore, emulationPinAIn, emulationPinBIn;
  logic testDataOut_ff, testDataOutEnN_ff, emuIrqFromA_ff, emuIrqFromB_ff;
  logic hostPortReadyOut_ff, hostPortReadyOutEnN_ff, hostInterruptOut_ff;
  logic hostInterruptOutEnN_ff, scanControl_ff, outputDisable_ff;
  stp_pkg::stp_scan_in_t scanIn;
  stp_pkg::stp_emu_drive_t emuDrive_ff;
  int bad_count = 0;
  int n_compared = 0;
  // a pin follows the device while it drives, else the emulator side
  assign emulationPinAIn = emuDrive_ff.emuAOutEnN ? pinADrv :
    emuDrive_ff.emuAOut;
  assign emulationPinBIn = emuDrive_ff.emuBOutEnN ? pinBDrv :
    emuDrive_ff.emuBOut;
  stp_scan_port #(.ID_CODE(ID)) i_stp_scan_port (.clk_sys, .nrst, .scanIn,
    .testDataOut_ff, .testDataOutEnN_ff, .emulationPinAIn, .emulationPinBIn,
    .emuDrive_ff, .coreEmuIrqA, .coreEmuIrqB, .emuIrqFromA_ff,
    .emuIrqFromB_ff, .hostReadyCore, .hostIntCore, .hostPortReadyOut_ff,
    .hostPortReadyOutEnN_ff, .hostInterruptOut_ff, .hostInterruptOutEnN_ff,
    .scanControl_ff, .outputDisable_ff);
  stp_tester i_stp_tester (.scanIn, .tdo(testDataOut_ff),
    .tdoEnN(testDataOutEnN_ff));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : waitClk
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // every combination of test reset and the two emulation pins
  task automatic offCheck();
    for (int k = 0; k < 8; k++) begin
      i_stp_tester.setReset(k[2]);
      @(posedge clk_sys);
      pinADrv <= k[1];
      pinBDrv <= k[0];
      coreEmuIrqA <= k[0];
      coreEmuIrqB <= !k[0];
      hostReadyCore <= k[0];
      hostIntCore <= !k[0];
      waitClk(8);
      check({outputDisable_ff, hostPortReadyOutEnN_ff, hostInterruptOutEnN_ff,
        testDataOutEnN_ff}, {{3{k == 2}}, 1'b1});
      check({scanControl_ff, hostPortReadyOut_ff, hostInterruptOut_ff},
        {k[2], k[0], !k[0]});
      check({emuIrqFromA_ff, emuIrqFromB_ff},
        {k[2] && !k[1], k[2] && !k[0]});
    end
  endtask : offCheck
  task automatic scanCheck();
    logic [31:0] q;
    int n;
    i_stp_tester.home();
    i_stp_tester.scan(1'b1, 4, 32'h8, q, n);
    check(q, 32'h1);
    check(n, 4);
    i_stp_tester.scan(1'b0, 2, 32'h3, q, n);
    check(q, 32'h0);
    check(emuDrive_ff, 4'h8);
    i_stp_tester.scan(1'b1, 4, 32'h1, q, n);
    i_stp_tester.scan(1'b0, 32, 32'h0, q, n);
    check(q, ID);
    check(testDataOutEnN_ff, 1'b1);
    i_stp_tester.scan(1'b1, 4, 32'hF, q, n);
    i_stp_tester.scan(1'b0, 8, 32'hB5, q, n);
    check(q, 32'h6A);
    i_stp_tester.setReset(1'b0);
    waitClk(8);
    check({emuDrive_ff.emuAOutEnN, emuDrive_ff.emuBOutEnN, scanControl_ff},
      3'b110);
    i_stp_tester.scan(1'b0, 4, 32'hF, q, n);
    check(n, 0);
  endtask : scanCheck
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // whole run is near 13 us of test clock traffic
  initial begin
    #100us;
    bad_count++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    pinADrv = 1'b0;
    pinBDrv = 1'b1;
    coreEmuIrqA = 1'b0;
    coreEmuIrqB = 1'b0;
    hostReadyCore = 1'b0;
    hostIntCore = 1'b0;
    waitClk(11);
    check({testDataOutEnN_ff, emuDrive_ff, hostPortReadyOutEnN_ff,
      hostInterruptOutEnN_ff, hostInterruptOut_ff, scanControl_ff,
      outputDisable_ff}, 10'h2A4);
    @(posedge clk_sys);
    nrst <= 1'b1;
    offCheck();
    scanCheck();
    test_done();
  end
endmodule : stp_scan_port_test
